// >>> alr_routing.sv
// Alarm latch, loop-break detector and output source routing.
// Assumes event and key strobes are synchronous one-cycle pulses; field alarms are pins.
module alr_routing #(
    parameter int TICK_CYCLES = alr_pkg::ALR_TICK_CYCLES,
    parameter int AUX_COUNT = 4,
    parameter bit HAS_CONTROL2 = 1'b1,
    parameter bit HAS_HEATER_DETECT = 1'b1
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    // Field alarm pins, asynchronous
    input wire logic [3:0] alarm_in,
    input wire logic heater_break_alarm,
    input wire logic input_error,
    input wire logic remote_point_error,
    input wire logic [9:0] heater_current,
    input wire logic [9:0] short_alarm_threshold,
    // Settings, same clock
    input wire logic short_alarm_use,
    input wire logic short_alarm_latch_enable,
    input wire logic [9:0] short_alarm_hysteresis,
    input wire logic function_key_latch_cancel,
    input wire logic event_latch_cancel,
    input wire logic setting_level_active,
    input wire logic [3:0] alarm1_type,
    input wire logic [13:0] loop_break_time,
    input wire logic [13:0] loop_break_level,
    input wire logic [13:0] loop_break_band,
    input wire logic [13:0] deviation,
    input wire logic heat_cool_mode,
    input wire logic heat_out,
    input wire logic cool_out,
    input wire logic run_state,
    input wire logic program_end,
    input wire logic program_pattern_on,
    input wire logic logic_operation_used,
    input wire logic [7:0] work_bits,
    input wire logic [7:0] integrated_alarm_mask,
    input wire logic [1:0] control_linear,
    input wire logic [4:0] control_source [2],
    input wire logic [4:0] aux_source [AUX_COUNT],
    input wire logic use_default_sources,
    output logic [1:0] control_output,
    output logic [AUX_COUNT-1:0] aux_output,
    output logic heater_short_alarm,
    output logic loop_break_alarm,
    output logic integrated_alarm
);
    // =========================================
    // Synchronisers for field pins
    logic [6:0] sync_a;
    logic [6:0] sync_b;
    logic [9:0] cur_a;
    logic [9:0] cur_b;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sync_a <= 7'h00;
            sync_b <= 7'h00;
            cur_a <= 10'h000;
            cur_b <= 10'h000;
        end else if (clock_enable) begin
            sync_a <= {remote_point_error, input_error, heater_break_alarm, alarm_in};
            sync_b <= sync_a;
            cur_a <= heater_current;
            cur_b <= cur_a;
        end
    end
    wire [3:0] alarm_s = sync_b[3:0];
    wire break_s = sync_b[4];
    wire input_err_s = sync_b[5];
    wire remote_err_s = sync_b[6];

    // =========================================
    // Heater short detection
    // A short shows as current at or above threshold, whatever the state of heat_out.
    wire [10:0] release_sum = {1'b0, short_alarm_threshold} - {1'b0, short_alarm_hysteresis};
    wire [9:0] release_level = release_sum[10] ? 10'h000 : release_sum[9:0];
    wire use_hyst = short_alarm_use && !short_alarm_latch_enable;
    wire short_raw_set = short_alarm_use && (cur_b >= short_alarm_threshold);
    wire short_raw_clr = use_hyst ? (cur_b < release_level) : (cur_b < short_alarm_threshold);
    wire latch_clear = (short_alarm_threshold == alr_pkg::ALR_CURRENT_MAX)
        || function_key_latch_cancel || event_latch_cancel;
    logic short_state;
    logic short_held;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            short_state <= 1'b0;
            short_held <= 1'b0;
        end else if (clock_enable) begin
            if (!short_alarm_use) begin
                short_state <= 1'b0;
            end else if (short_raw_set) begin
                short_state <= 1'b1;
            end else if (short_raw_clr) begin
                short_state <= 1'b0;
            end
            // Set wins over clear so a fresh fault is never lost
            if (!short_alarm_use || !short_alarm_latch_enable) begin
                short_held <= 1'b0;
            end else if (short_raw_set) begin
                short_held <= 1'b1;
            end else if (latch_clear) begin
                short_held <= 1'b0;
            end
        end
    end
    wire short_s = (short_state || short_held) && !(short_alarm_latch_enable && setting_level_active);

    // =========================================
    // One-second tick and loop-break timer
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    logic [TICK_W-1:0] tick_count;
    logic tick;
    wire lb_enabled = (alarm1_type == alr_pkg::ALR_LB_ALARM_TYPE)
        && (loop_break_time != 14'h0000);
    alr_pkg::alr_lb_e lb_state;
    alr_pkg::alr_lb_e next_lb_state;
    logic [13:0] lb_seconds;
    logic [13:0] lb_ref_dev;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tick_count <= '0;
            tick <= 1'b0;
        end else if (clock_enable) begin
            tick <= (tick_count == TICK_W'(TICK_CYCLES - 1));
            tick_count <= (tick_count == TICK_W'(TICK_CYCLES - 1)) ? '0 : tick_count + 1'b1;
        end
    end
    wire over_level = deviation > loop_break_level;
    wire reduced = (lb_ref_dev > deviation) && ((lb_ref_dev - deviation) > loop_break_band);
    wire period_done = tick && (lb_seconds + 14'h0001 >= loop_break_time);
    always_comb begin
        next_lb_state = lb_state;
        case (lb_state)
            alr_pkg::alr_lb_idle: if (over_level) next_lb_state = alr_pkg::alr_lb_watch;
            alr_pkg::alr_lb_watch: begin
                if (!over_level) next_lb_state = alr_pkg::alr_lb_idle;
                else if (period_done && !reduced) next_lb_state = alr_pkg::alr_lb_trip;
            end
            alr_pkg::alr_lb_trip: if (!over_level || (period_done && reduced)) next_lb_state = alr_pkg::alr_lb_idle;
            default: next_lb_state = alr_pkg::alr_lb_idle;
        endcase
        if (!lb_enabled) next_lb_state = alr_pkg::alr_lb_idle;
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            lb_state <= alr_pkg::alr_lb_idle;
            lb_seconds <= 14'h0000;
            lb_ref_dev <= 14'h0000;
        end else if (clock_enable) begin
            lb_state <= next_lb_state;
            if (!lb_enabled || lb_state == alr_pkg::alr_lb_idle || period_done) begin
                lb_seconds <= 14'h0000;
                lb_ref_dev <= deviation;
            end else if (tick) begin
                lb_seconds <= lb_seconds + 14'h0001;
            end
        end
    end
    wire lb_active = (lb_state == alr_pkg::alr_lb_trip);
    // Loop break replaces alarm 1 when that channel is configured for it
    wire alarm1_eff = lb_enabled ? lb_active : alarm_s[0];

    // =========================================
    // Integrated alarm
    wire [7:0] int_sources = {remote_err_s, input_err_s, short_s, break_s, alarm_s[3:1], alarm1_eff};
    wire int_alarm = |(int_sources & integrated_alarm_mask);

    // =========================================
    // Source routing
    function automatic logic route(input logic [4:0] sel, input logic linear_out);
        logic status_ok;
        logic val;
        status_ok = !linear_out;
        val = 1'b0;
        case (sel)
            alr_pkg::alr_src_heat: val = heat_out;
            alr_pkg::alr_src_cool: val = heat_cool_mode && cool_out;
            alr_pkg::alr_src_alarm1: val = status_ok && alarm1_eff;
            alr_pkg::alr_src_alarm2: val = status_ok && alarm_s[1];
            alr_pkg::alr_src_alarm3: val = status_ok && alarm_s[2];
            alr_pkg::alr_src_alarm4: val = status_ok && alarm_s[3];
            alr_pkg::alr_src_heater: val = status_ok && (break_s || short_s);
            alr_pkg::alr_src_break: val = status_ok && break_s;
            alr_pkg::alr_src_short: val = status_ok && short_s;
            alr_pkg::alr_src_input_err: val = status_ok && input_err_s;
            alr_pkg::alr_src_remote_err: val = status_ok && remote_err_s;
            alr_pkg::alr_src_prog_end: val = status_ok && program_pattern_on && program_end;
            alr_pkg::alr_src_run: val = status_ok && run_state;
            alr_pkg::alr_src_integrated: val = status_ok && int_alarm;
            default: begin
                if (sel >= alr_pkg::alr_src_work1 && sel <= alr_pkg::ALR_SRC_WORK8) begin
                    val = status_ok && logic_operation_used
                        && work_bits[3'(sel - alr_pkg::alr_src_work1)];
                end
            end
        endcase
        return val;
    endfunction

    // Default assignments when software has not chosen its own
    wire [4:0] ctrl1_sel = use_default_sources ? 5'(alr_pkg::alr_src_heat) : control_source[0];
    wire [4:0] ctrl2_sel = (HAS_CONTROL2 && heat_cool_mode) ? 5'(alr_pkg::alr_src_cool)
        : (use_default_sources ? 5'(alr_pkg::alr_src_none) : control_source[1]);
    logic [4:0] aux_sel [AUX_COUNT];
    always_comb begin
        for (int i = 0; i < AUX_COUNT; i++) begin
            aux_sel[i] = use_default_sources ? 5'(5'(alr_pkg::alr_src_alarm1) + 5'(i)) : aux_source[i];
        end
        if (use_default_sources && HAS_HEATER_DETECT) aux_sel[0] = alr_pkg::alr_src_heater;
        if (!HAS_CONTROL2 && heat_cool_mode) begin
            if (AUX_COUNT >= 4) aux_sel[AUX_COUNT >= 4 ? 3 : 0] = alr_pkg::alr_src_cool;
            else if (AUX_COUNT >= 2) aux_sel[AUX_COUNT >= 2 ? 1 : 0] = alr_pkg::alr_src_cool;
        end
    end
    logic [AUX_COUNT-1:0] next_aux;
    always_comb begin
        for (int i = 0; i < AUX_COUNT; i++) begin
            next_aux[i] = route(aux_sel[i], 1'b0);
        end
    end

    // =========================================
    // Registered outputs
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            control_output <= 2'b00;
            aux_output <= '0;
            heater_short_alarm <= 1'b0;
            loop_break_alarm <= 1'b0;
            integrated_alarm <= 1'b0;
        end else if (clock_enable) begin
            control_output <= {route(ctrl2_sel, control_linear[1]), route(ctrl1_sel, control_linear[0])};
            aux_output <= next_aux;
            heater_short_alarm <= short_s;
            loop_break_alarm <= lb_active;
            integrated_alarm <= int_alarm;
        end
    end
endmodule

// >>> alr_pkg.sv
// Constants and types for the alarm latch and output routing block.
// Assumes settings arrive as plain ports, already validated by the front panel logic.
// Summary of operation
// - Latch on holds short alarm until cleared
// - Current setting of 50.0 A releases latch
// - Power-up, function key, event input release latch
// - Setting levels force latched output off
// - Short alarm hysteresis 0.1 to 50.0 A
// - Hysteresis used only when unlatched and enabled
// - Loop-break time 0 to 9999 s, 0 disables
// - Loop break only on alarm 1, type 12
// - Deviation above level flags loop break
// - Deviation above band not reduced flags break
// - Control outputs take a selectable source
// - Cooling under standard control outputs 0%
// - Status sources only on relay or voltage outputs
// - Heating/cooling moves control output 2 to cooling
// - Auxiliary outputs default to alarms 1 to 4
// - No control output 2: cooling to aux 4/2
// - Program end inactive while pattern is off
// - Work bits hidden without logic operation
// - Heater detection fitted: aux 1 defaults heater alarm
// - Integrated alarm ORs masked weighted sources
// - Mask 0 to 255, default 49
// - Short alarm enable gates short alarm generation
package alr_pkg;
    // =========================================
    // Output source codes
    typedef enum logic [4:0] {
        alr_src_none = 5'h00,
        alr_src_heat = 5'h01,
        alr_src_cool = 5'h02,
        alr_src_alarm1 = 5'h03,
        alr_src_alarm2 = 5'h04,
        alr_src_alarm3 = 5'h05,
        alr_src_alarm4 = 5'h06,
        alr_src_heater = 5'h07,
        alr_src_break = 5'h08,
        alr_src_short = 5'h09,
        alr_src_input_err = 5'h0a,
        alr_src_remote_err = 5'h0b,
        alr_src_prog_end = 5'h0c,
        alr_src_run = 5'h0d,
        alr_src_integrated = 5'h0e,
        alr_src_work1 = 5'h0f
    } alr_src_e;
    localparam logic [4:0] ALR_SRC_WORK8 = 5'h16;
    // =========================================
    // Loop-break detector states
    typedef enum logic [1:0] {
        alr_lb_idle = 2'b00,
        alr_lb_watch = 2'b01,
        alr_lb_trip = 2'b11
    } alr_lb_e;
    // =========================================
    // Settings, currents in 0.1 A, temperatures in 0.1 degree
    localparam logic [9:0] ALR_CURRENT_MAX = 10'h1f4;
    localparam logic [9:0] ALR_HYST_MIN = 10'h001;
    localparam logic [9:0] ALR_HYST_DEFAULT = 10'h001;
    localparam logic [13:0] ALR_LB_TIME_MAX = 14'h270f;
    localparam logic [13:0] ALR_LB_TIME_DEFAULT = 14'h0000;
    localparam logic [3:0] ALR_LB_ALARM_TYPE = 4'hc;
    localparam logic [13:0] ALR_LB_LEVEL_MIN = 14'h0001;
    localparam logic [13:0] ALR_LB_LEVEL_DEFAULT = 14'h0050;
    localparam logic [13:0] ALR_LB_BAND_DEFAULT = 14'h001e;
    localparam logic [13:0] ALR_DEV_MAX = 14'h270f;
    localparam logic [7:0] ALR_MASK_DEFAULT = 8'h31;
    localparam int ALR_MASK_ALARM1 = 0;
    localparam int ALR_MASK_BREAK = 4;
    localparam int ALR_MASK_SHORT = 5;
    localparam int ALR_MASK_REMOTE = 7;
    localparam int ALR_CLOCK_HZ = 50000000;
    localparam int ALR_TICK_S = 1;
    localparam int ALR_TICK_CYCLES = ALR_CLOCK_HZ * ALR_TICK_S;
endpackage

// >>> alr_load_model.sv
// Relay or solid-state load model standing on the routed outputs.
// Assumes one clock; each contact follows its drive one cycle late.
module alr_load_model #(
    parameter int N = 4
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [N-1:0] drive,
    output logic [N-1:0] energised
);
    // ==========================
    // Contacts
    // Loads drop out on reset, as on loss of supply
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            energised <= '0;
        end else begin
            energised <= drive;
        end
    end
endmodule

// >>> alr_routing_checker.sv
// Concurrent checks on routed outputs, short alarm and loop break.
// Assumes it is bound to alr_routing and sees only its ports.
module alr_routing_checker (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire logic short_alarm_use,
    input wire logic short_alarm_latch_enable,
    input wire logic setting_level_active,
    input wire logic [13:0] loop_break_time,
    input wire logic heat_cool_mode,
    input wire logic heat_out,
    input wire logic program_pattern_on,
    input wire logic logic_operation_used,
    input wire logic [7:0] integrated_alarm_mask,
    input wire logic [1:0] control_linear,
    input wire logic [4:0] control_source [2],
    input wire logic use_default_sources,
    input wire logic [1:0] control_output,
    input wire logic heater_short_alarm,
    input wire logic loop_break_alarm,
    input wire logic integrated_alarm
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Source ports only count with defaults off
    wire logic pick = clock_enable && !use_default_sources;
    wire logic [4:0] src0 = control_source[0];
    // ==========================
    // Sequences
    sequence s_level_latched;
        clock_enable && setting_level_active && short_alarm_latch_enable;
    endsequence
    sequence s_short_off;
        clock_enable && !short_alarm_use;
    endsequence
    sequence s_break_off;
        clock_enable && loop_break_time == 14'h0000;
    endsequence
    // ==========================
    // Properties
    property p_level_mask;
        s_level_latched [*2] |=> !heater_short_alarm;
    endproperty
    a_level_mask: assert property (p_level_mask) else $error("short alarm shown in setting level");
    property p_short_gate;
        s_short_off [*2] |=> !heater_short_alarm;
    endproperty
    a_short_gate: assert property (p_short_gate) else $error("short alarm while unused");
    property p_break_off;
        s_break_off [*2] |=> !loop_break_alarm;
    endproperty
    a_break_off: assert property (p_break_off) else $error("loop break with zero time");
    property p_mask_zero;
        clock_enable && integrated_alarm_mask == 8'h00 |=> !integrated_alarm;
    endproperty
    a_mask_zero: assert property (p_mask_zero) else $error("integrated alarm with empty mask");
    property p_heat_route;
        pick && src0 == 5'h01 |=> control_output[0] == $past(heat_out);
    endproperty
    a_heat_route: assert property (p_heat_route) else $error("heating source not routed");
    property p_cool_std;
        pick && src0 == 5'h02 && !heat_cool_mode |=> !control_output[0];
    endproperty
    a_cool_std: assert property (p_cool_std) else $error("cooling on in standard control");
    property p_linear;
        pick && control_linear[0] && src0 >= 5'h03 |=> !control_output[0];
    endproperty
    a_linear: assert property (p_linear) else $error("status source on linear output");
    property p_prog_end;
        pick && src0 == 5'h0c && !program_pattern_on |=> !control_output[0];
    endproperty
    a_prog_end: assert property (p_prog_end) else $error("program end active with pattern off");
    property p_work_hidden;
        pick && src0 >= 5'h0f && src0 <= 5'h16 && !logic_operation_used |=> !control_output[0];
    endproperty
    a_work_hidden: assert property (p_work_hidden) else $error("work bit without logic operation");
endmodule

bind alr_routing alr_routing_checker u_checker (.clock, .reset, .clock_enable, .short_alarm_use,
    .short_alarm_latch_enable, .setting_level_active, .loop_break_time, .heat_cool_mode, .heat_out,
    .program_pattern_on, .logic_operation_used, .integrated_alarm_mask, .control_linear, .control_source,
    .use_default_sources, .control_output, .heater_short_alarm, .loop_break_alarm, .integrated_alarm);

// >>> tb_top.sv
// Self-checking bench for the alarm latch and output routing block.
// Assumes a 50 MHz clock and a one-second tick shortened to 10 cycles.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [4:0] src; logic lin; logic hc; logic pat; logic lop; logic exp;} alr_row_s;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [3:0] alarm_in = 4'hf;
    logic heater_break_alarm = 1'b1, input_error = 1'b1, remote_point_error = 1'b1;
    logic [9:0] heater_current = 10'h064, short_alarm_threshold = 10'h032, short_alarm_hysteresis = 10'h001;
    logic short_alarm_use = 1'b1, short_alarm_latch_enable = 1'b0, function_key_latch_cancel = 1'b0;
    logic event_latch_cancel = 1'b0, setting_level_active = 1'b0, heat_cool_mode = 1'b1;
    logic [3:0] alarm1_type = 4'h0;
    logic [13:0] loop_break_time = 14'h0000, loop_break_level = 14'h0050, loop_break_band = 14'h001e;
    logic [13:0] deviation = 14'h0000;
    logic heat_out = 1'b1, cool_out = 1'b1, run_state = 1'b1, program_end = 1'b1, program_pattern_on = 1'b1;
    logic logic_operation_used = 1'b1, use_default_sources = 1'b0;
    logic [7:0] work_bits = 8'hff, integrated_alarm_mask = 8'h31;
    logic [1:0] control_linear = 2'b00, control_output;
    logic [4:0] control_source [2] = '{5'h01, 5'h00};
    logic [4:0] aux_source [4] = '{5'h03, 5'h04, 5'h05, 5'h06};
    logic [3:0] aux_output, load_on;
    logic heater_short_alarm, loop_break_alarm, integrated_alarm;
    logic [9:0] hy_cur [3] = '{10'h064, 10'h05b, 10'h059};
    logic [2:0] hy_exp = 3'b011;
    int err_count = 0, n_checks = 0, cycles = 0;
    alr_row_s rows [8] = '{'{5'h02, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0}, '{5'h02, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1},
        '{5'h03, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0}, '{5'h0d, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1},
        '{5'h01, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1}, '{5'h0c, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0},
        '{5'h0c, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1}, '{5'h0f, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0}};

    alr_routing #(.TICK_CYCLES(10)) dut (.clock, .reset, .clock_enable(1'b1), .alarm_in, .heater_break_alarm,
        .input_error, .remote_point_error, .heater_current, .short_alarm_threshold, .short_alarm_use,
        .short_alarm_latch_enable, .short_alarm_hysteresis, .function_key_latch_cancel, .event_latch_cancel,
        .setting_level_active, .alarm1_type, .loop_break_time, .loop_break_level, .loop_break_band, .deviation,
        .heat_cool_mode, .heat_out, .cool_out, .run_state, .program_end, .program_pattern_on,
        .logic_operation_used, .work_bits, .integrated_alarm_mask, .control_linear, .control_source,
        .aux_source, .use_default_sources, .control_output, .aux_output, .heater_short_alarm,
        .loop_break_alarm, .integrated_alarm);
    alr_load_model #(.N(4)) u_load (.clock, .reset, .drive(aux_output), .energised(load_on));

    // ==========================
    // Helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_checks++;
        if (seen !== want) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    // Sample one step past the edge so its updates have landed
    task automatic wait_edges(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic lb_case(input logic [3:0] ty, input logic [13:0] tm, input logic [13:0] dv, input logic want);
        @(posedge clock);
        alarm1_type <= ty;
        loop_break_time <= tm;
        deviation <= dv;
        wait_edges(100);
        check(loop_break_alarm, want);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================
    // Clock, timeout, sequence
    initial begin
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        logic [7:0] v;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        foreach (rows[i]) begin
            @(posedge clock);
            control_source[0] <= rows[i].src;
            control_linear <= {1'b0, rows[i].lin};
            heat_cool_mode <= rows[i].hc;
            program_pattern_on <= rows[i].pat;
            logic_operation_used <= rows[i].lop;
            wait_edges(4);
            check(control_output[0], rows[i].exp);
        end
        @(posedge clock);
        logic_operation_used <= 1'b1;
        for (int c = 0; c <= 22; c++) begin
            @(posedge clock);
            aux_source[0] <= 5'(c);
            wait_edges(4);
            check(aux_output[0], c != 0);
        end
        $display("source selection done");
        @(posedge clock);
        use_default_sources <= 1'b1;
        alarm_in <= 4'b0100;
        heat_out <= 1'b0;
        wait_edges(5);
        check({control_output, aux_output}, 8'h25);
        check(load_on, 4'b0101);
        @(posedge clock);
        heat_cool_mode <= 1'b0;
        wait_edges(4);
        check(control_output, 2'b00);
        @(posedge clock);
        use_default_sources <= 1'b0;
        for (int b = 0; b < 16; b++) begin
            v = 8'h01 << (b / 2);
            @(posedge clock);
            alarm_in <= v[3:0];
            heater_break_alarm <= v[4];
            heater_current <= v[5] ? 10'h064 : 10'h000;
            input_error <= v[6];
            remote_point_error <= v[7];
            integrated_alarm_mask <= b[0] ? v : ~v;
            wait_edges(6);
            check(integrated_alarm, b[0]);
        end
        @(posedge clock);
        integrated_alarm_mask <= 8'h00;
        wait_edges(3);
        check(integrated_alarm, 1'b0);
        $display("defaults and integrated alarm done");
        @(posedge clock);
        short_alarm_latch_enable <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            heater_current <= 10'h064;
            wait_edges(6);
            @(posedge clock);
            heater_current <= 10'h000;
            wait_edges(6);
            check(heater_short_alarm, 1'b1);
            @(posedge clock);
            event_latch_cancel <= (k == 0);
            function_key_latch_cancel <= (k == 1);
            short_alarm_threshold <= (k == 2) ? 10'h1f4 : 10'h032;
            setting_level_active <= (k == 3);
            @(posedge clock);
            event_latch_cancel <= 1'b0;
            function_key_latch_cancel <= 1'b0;
            wait_edges(4);
            check(heater_short_alarm, 1'b0);
            @(posedge clock);
            short_alarm_threshold <= 10'h032;
            setting_level_active <= 1'b0;
        end
        // Latch still held after the last pass; a mid-run reset drops it next
        wait_edges(2);
        check(heater_short_alarm, 1'b1);
        @(posedge clock);
        reset <= 1'b1;
        wait_edges(1);
        check(heater_short_alarm, 1'b0);
        @(posedge clock);
        reset <= 1'b0;
        wait_edges(2);
        check(heater_short_alarm, 1'b0);
        $display("mid-run reset done");
        @(posedge clock);
        short_alarm_use <= 1'b0;
        heater_current <= 10'h064;
        wait_edges(6);
        check(heater_short_alarm, 1'b0);
        @(posedge clock);
        short_alarm_use <= 1'b1;
        short_alarm_latch_enable <= 1'b0;
        short_alarm_threshold <= 10'h064;
        short_alarm_hysteresis <= 10'h00a;
        foreach (hy_cur[i]) begin
            @(posedge clock);
            heater_current <= hy_cur[i];
            wait_edges(6);
            check(heater_short_alarm, hy_exp[i]);
        end
        $display("short alarm done");
        lb_case(4'hc, 14'h0002, 14'h0064, 1'b1);
        lb_case(4'hc, 14'h0002, 14'h0050, 1'b0);
        // Deviation falls 4 per cycle, beyond the band within any period
        @(posedge clock);
        deviation <= 14'h0300;
        repeat (100) begin
            @(posedge clock);
            deviation <= deviation - 14'h0004;
        end
        wait_edges(0);
        check(loop_break_alarm, 1'b0);
        lb_case(4'hc, 14'h0002, 14'h0064, 1'b1);
        lb_case(4'hc, 14'h0000, 14'h0064, 1'b0);
        lb_case(4'h1, 14'h0002, 14'h0064, 1'b0);
        $display("loop break done");
        give_verdict();
    end
endmodule
